// ### hdl/mgmt_pkg.sv
package mgmt_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int STRB_W = 4;

    // register byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GUARD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PEAK = 8'h0c;
    localparam logic [7:0] OFS_STRAP = 8'h10;

    // control register fields
    localparam int CTRL_SRST = 0;
    localparam int CTRL_TRIG = 1;
    localparam int CTRL_ISO = 2;
    localparam int CTRL_MODE = 4;
    localparam int CTRL_TEST = 8;
    localparam int CTRL_OVR = 15;
    localparam int MODE_W = 4;
    localparam int TEST_W = 4;

    // status register fields
    localparam int STAT_HI = 0;
    localparam int STAT_LO = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_RST = 3;

    // field widths
    localparam int PEAK_W = 3;
    localparam int STRAP_W = 5;
    localparam int GUARD_W = 8;

    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 4'h1;
    localparam logic [TEST_W-1:0] TEST_RST = 4'h0;
    localparam logic [GUARD_W-1:0] GUARD_RST = 8'h00;
    localparam logic STICKY_HI_RST = 1'b0;
    localparam logic STICKY_LO_RST = 1'b1;
    localparam logic [PEAK_W-1:0] PEAK_RST = 3'h0;
    localparam logic [STRAP_W-1:0] STRAP_ZERO = 5'h00;

    // timing
    localparam int CLOCK_NS = 10;
    localparam int SOFT_RESET_NS = 40;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int STRAP_SETTLE = 2;
    localparam int CNT_W = 3;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PH_STRAP = 2'b00,
        PH_RUN = 2'b01,
        PH_SOFT = 2'b10
    } phase_t;
endpackage

// ### hdl/mon_if.sv
`timescale 1ns/1ps
interface mon_if;
    import mgmt_pkg::*;
    logic clr;
    logic rd_flags;
    logic rd_peak;
    logic ev_high;
    logic ev_low_n;
    logic [PEAK_W-1:0] fsm_state;
    logic sticky_hi;
    logic sticky_lo;
    logic [PEAK_W-1:0] peak;

    modport tracker (
        input clr, rd_flags, rd_peak, ev_high, ev_low_n, fsm_state,
        output sticky_hi, sticky_lo, peak
    );
    modport regs (
        output clr, rd_flags, rd_peak, ev_high, ev_low_n, fsm_state,
        input sticky_hi, sticky_lo, peak
    );
endinterface

// ### hdl/event_tracker.sv
`timescale 1ns/1ps
module event_tracker (
    input wire logic clock,
    input wire logic rst_n,
    mon_if.tracker mon
);
    import mgmt_pkg::*;

    typedef struct packed {
        logic hi;
        logic lo;
        logic [PEAK_W-1:0] peak;
    } track_t;

    localparam track_t TRACK_RST = '{hi: STICKY_HI_RST, lo: STICKY_LO_RST, peak: PEAK_RST};

    track_t s;
    track_t next_s;

    // a read reloads with the live value; the set term rides along so no event is lost
    always_comb begin
        next_s = s;
        if (mon.clr) begin
            next_s = TRACK_RST;
        end else begin
            next_s.hi = mon.rd_flags ? mon.ev_high : (s.hi | mon.ev_high);
            next_s.lo = mon.rd_flags ? mon.ev_low_n : (s.lo & mon.ev_low_n);
            if (mon.rd_peak) begin
                next_s.peak = mon.fsm_state;
            end else if (mon.fsm_state > s.peak) begin
                next_s.peak = mon.fsm_state;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= TRACK_RST;
        end else begin
            s <= next_s;
        end
    end

    assign mon.sticky_hi = s.hi;
    assign mon.sticky_lo = s.lo;
    assign mon.peak = s.peak;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_sticky_hi_hold: assert property (s.hi && !mon.rd_flags && !mon.clr |=> s.hi)
        else $error("sticky high flag dropped without a read");
    a_sticky_lo_hold: assert property (!s.lo && !mon.rd_flags && !mon.clr |=> !s.lo)
        else $error("sticky low flag rose without a read");
    a_flag_reload: assert property (mon.rd_flags && !mon.clr
        |=> s.hi == $past(mon.ev_high) && s.lo == $past(mon.ev_low_n))
        else $error("flags not reloaded with live level after read");
    a_peak_no_drop: assert property (!mon.rd_peak && !mon.clr |=> s.peak >= $past(s.peak))
        else $error("peak group fell without a read");
    a_peak_capture: assert property (!mon.rd_peak && !mon.clr && mon.fsm_state > s.peak
        |=> s.peak == $past(mon.fsm_state))
        else $error("higher state value not captured");
    a_peak_reload: assert property (mon.rd_peak && !mon.clr |=> s.peak == $past(mon.fsm_state))
        else $error("peak group not reloaded after read");

    c_hi_event_read: cover property (mon.ev_high ##1 !mon.ev_high [*2] ##1 mon.rd_flags);
endmodule

// ### hdl/mgmt_bits.sv
`timescale 1ns/1ps
module mgmt_bits (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [mgmt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [mgmt_pkg::DATA_W-1:0] wdata,
    input wire logic [mgmt_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [mgmt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [mgmt_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic addr_strap_pin_0,
    input wire logic addr_strap_pin_1,
    input wire logic addr_strap_pin_2,
    input wire logic addr_strap_pin_3,
    input wire logic addr_strap_pin_4,
    input wire logic event_high,
    input wire logic event_low_n,
    input wire logic [mgmt_pkg::PEAK_W-1:0] fsm_state,
    input wire logic func_done,
    output logic func_start,
    output logic isolate,
    output logic [mgmt_pkg::MODE_W-1:0] cfg_mode,
    output logic [mgmt_pkg::TEST_W-1:0] test_mode,
    output logic [mgmt_pkg::GUARD_W-1:0] guarded_cfg,
    output logic soft_reset_active
);
    import mgmt_pkg::*;

    typedef struct packed {
        phase_t phase;
        logic rst_busy;
        logic [CNT_W-1:0] cnt;
        logic [STRAP_W-1:0] strap_s1;
        logic [STRAP_W-1:0] strap_s2;
        logic [STRAP_W-1:0] strap;
        logic isolate;
        logic override;
        logic trig;
        logic func_start;
        logic [MODE_W-1:0] mode;
        logic [TEST_W-1:0] test;
        logic [GUARD_W-1:0] guard;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } regs_t;

    localparam regs_t REGS_RST = '{phase: PH_STRAP, rst_busy: 1'b1, mode: MODE_RST, test: TEST_RST, guard: GUARD_RST,
                                   default: '0};

    regs_t s;
    regs_t next_s;
    logic wr_fire;
    logic rd_fire;
    logic [REG_W-1:0] wr_val;

    mon_if mon ();

    event_tracker tracker (
        .clock(clock),
        .rst_n(rst_n),
        .mon(mon)
    );

    // address decode shared by the write and read paths
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_CTRL) || (a == OFS_GUARD) || (a == OFS_STATUS) ||
                    (a == OFS_PEAK) || (a == OFS_STRAP);
    endfunction

    // byte-lane merge; only the two low lanes carry register bits
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [DATA_W-1:0] d,
                                               input logic [STRB_W-1:0] st);
        merge = old;
        if (st[0]) begin
            merge[7:0] = d[7:0];
        end
        if (st[1]) begin
            merge[15:8] = d[15:8];
        end
    endfunction

    function automatic logic [REG_W-1:0] ctrl_word(input regs_t r);
        ctrl_word = '0;
        ctrl_word[CTRL_SRST] = (r.phase != PH_RUN);
        ctrl_word[CTRL_TRIG] = r.trig;
        ctrl_word[CTRL_ISO] = r.isolate;
        ctrl_word[CTRL_MODE +: MODE_W] = r.mode;
        ctrl_word[CTRL_TEST +: TEST_W] = r.test;
        ctrl_word[CTRL_OVR] = r.override;
    endfunction

    // read mux; narrower registers sit in the low bits
    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a, input regs_t r,
                                                    input logic hi, input logic lo,
                                                    input logic [PEAK_W-1:0] pk);
        read_word = '0;
        case (a)
            OFS_CTRL: begin
                read_word[REG_W-1:0] = ctrl_word(r);
            end
            OFS_GUARD: begin
                read_word[GUARD_W-1:0] = r.guard;
            end
            OFS_STATUS: begin
                read_word[STAT_HI] = hi;
                read_word[STAT_LO] = lo;
                read_word[STAT_BUSY] = r.trig;
                read_word[STAT_RST] = (r.phase != PH_RUN);
            end
            OFS_PEAK: begin
                read_word[PEAK_W-1:0] = pk;
            end
            OFS_STRAP: begin
                read_word[STRAP_W-1:0] = r.strap;
            end
            default: begin
                read_word = '0;
            end
        endcase
    endfunction

    // monitored inputs come from core logic on this clock, so no synchroniser
    assign mon.ev_high = event_high;
    assign mon.ev_low_n = event_low_n;
    assign mon.fsm_state = fsm_state;

    // next-state logic for the bus slave, control bits and reset sequencing
    always_comb begin
        next_s = s;
        wr_val = '0;
        next_s.func_start = 1'b0;
        next_s.strap_s1 = {addr_strap_pin_4, addr_strap_pin_3, addr_strap_pin_2,
                           addr_strap_pin_1, addr_strap_pin_0};
        next_s.strap_s2 = s.strap_s1;

        // function finished: trigger drops now; a soft reset also clears it
        if (s.trig && func_done) begin
            next_s.trig = 1'b0;
        end

        // write address and data are taken in either order
        if (s.awready && awvalid) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = awaddr;
        end
        if (s.wready && wvalid) begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        wr_fire = s.aw_held && s.w_held && !s.bvalid;
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = is_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
            // writes during a reset sequence are answered but have no effect
            if (s.phase == PH_RUN) begin
                if (s.override) begin
                    next_s.override = 1'b0;
                end
                case (s.awaddr)
                    OFS_CTRL: begin
                        wr_val = merge(ctrl_word(s), s.wdata, s.wstrb);
                        next_s.isolate = wr_val[CTRL_ISO];
                        next_s.mode = wr_val[CTRL_MODE +: MODE_W];
                        next_s.test = wr_val[CTRL_TEST +: TEST_W];
                        if (!s.override) begin
                            next_s.override = wr_val[CTRL_OVR];
                        end
                        if (wr_val[CTRL_TRIG] && !s.trig) begin
                            next_s.trig = 1'b1;
                            next_s.func_start = 1'b1;
                        end
                        if (wr_val[CTRL_SRST]) begin
                            next_s.phase = PH_SOFT;
                            next_s.cnt = '0;
                            next_s.trig = 1'b0;
                            next_s.func_start = 1'b0;
                            next_s.override = 1'b0;
                        end
                    end
                    OFS_GUARD: begin
                        wr_val = merge({{(REG_W-GUARD_W){1'b0}}, s.guard}, s.wdata, s.wstrb);
                        if (s.override) begin
                            next_s.guard = wr_val[GUARD_W-1:0];
                        end
                    end
                    default: begin
                        // status, peak and strap words are read-only
                        wr_val = '0;
                    end
                endcase
            end
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // read: data is sampled from the held values before the reload edge
        rd_fire = s.arready && arvalid;
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_word(araddr, s, mon.sticky_hi, mon.sticky_lo, mon.peak);
            next_s.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_s.arready = !next_s.rvalid;
        mon.rd_flags = rd_fire && (araddr == OFS_STATUS);
        mon.rd_peak = rd_fire && (araddr == OFS_PEAK);
        mon.clr = (s.phase == PH_SOFT);

        // reset sequencing: soft reset loads defaults, then straps are sampled again
        case (s.phase)
            PH_STRAP: begin
                next_s.cnt = s.cnt + 1'b1;
                // second stage holds the pin level only from the second edge on, so wait one more
                if (s.cnt == CNT_W'(STRAP_SETTLE)) begin
                    next_s.strap = s.strap_s2;
                    next_s.isolate = (s.strap_s2 == STRAP_ZERO);
                    next_s.phase = PH_RUN;
                    next_s.cnt = '0;
                end
            end
            PH_SOFT: begin
                next_s.cnt = s.cnt + 1'b1;
                next_s.mode = MODE_RST;
                next_s.test = TEST_RST;
                next_s.guard = GUARD_RST;
                next_s.override = 1'b0;
                next_s.trig = 1'b0;
                if (s.cnt == CNT_W'(SOFT_RESET_CYCLES - 1)) begin
                    next_s.phase = PH_STRAP;
                    next_s.cnt = '0;
                end
            end
            PH_RUN: begin
                next_s.cnt = '0;
            end
            default: begin
                next_s.phase = PH_STRAP;
                next_s.cnt = '0;
            end
        endcase
        // registered so the reset-in-progress output comes from a flop
        next_s.rst_busy = (next_s.phase != PH_RUN);
    end

    // synchronous reset takes constants only; straps are caught after release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= REGS_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;
    assign func_start = s.func_start;
    assign isolate = s.isolate;
    assign cfg_mode = s.mode;
    assign test_mode = s.test;
    assign guarded_cfg = s.guard;
    assign soft_reset_active = s.rst_busy;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_trig_held: assert property (s.trig && !func_done && s.phase == PH_RUN && !next_s.phase[1]
        |=> s.trig)
        else $error("trigger bit cleared before function finished");
    a_trig_start: assert property (s.func_start |-> s.trig ##1 !s.func_start)
        else $error("function start without trigger bit or longer than one cycle");
    a_trig_done: assert property (s.trig && func_done |=> !s.trig)
        else $error("trigger bit did not clear itself on completion");
    a_override_once: assert property (s.override && wr_fire |=> !s.override)
        else $error("override survived the following write");
    a_guard_locked: assert property (wr_fire && !s.override && s.phase != PH_SOFT |=> s.guard == $past(s.guard))
        else $error("guarded bits changed without override");
    a_ro_ignored: assert property (wr_fire && s.phase == PH_RUN |=> s.strap == $past(s.strap))
        else $error("read-only strap word changed on a write");
    a_strap_capture: assert property (s.phase == PH_STRAP && s.cnt == CNT_W'(STRAP_SETTLE)
        |=> s.strap == $past(s.strap_s2) && s.isolate == ($past(s.strap_s2) == STRAP_ZERO))
        else $error("strap level not captured at end of reset");
    a_soft_defaults: assert property (s.phase == PH_SOFT ##1 s.phase == PH_STRAP
        |-> s.mode == MODE_RST && s.guard == GUARD_RST && !s.trig)
        else $error("soft reset did not restore defaults");
    a_read_history: assert property (rd_fire && araddr == OFS_STATUS
        |=> s.rdata[STAT_HI] == $past(mon.sticky_hi) && s.rdata[STAT_LO] == $past(mon.sticky_lo))
        else $error("read returned reloaded value instead of history");

    c_guard_write: cover property (s.override ##[1:20] wr_fire && s.awaddr == OFS_GUARD);
    c_soft_reset: cover property (s.phase == PH_SOFT ##[1:10] s.phase == PH_RUN);
    c_peak_read_twice: cover property (mon.rd_peak ##[1:10] mon.rd_peak);
endmodule

// ### test/core_model.sv
`timescale 1ns/1ps
// core side: answers each start pulse with a one-cycle done lat+1 cycles after the edge that samples it
module core_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic func_start,
    input wire logic [3:0] lat,
    output logic func_done
);
    int cnt;
    // done is a pulse, so a level stuck high is never read as completion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt <= 0;
            func_done <= 1'b0;
        end else begin
            func_done <= (cnt == 1);
            if (func_start)
                cnt <= lat + 1;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// ### test/test_mgmt_register_bit_behaviour.sv
`timescale 1ns/1ps
module test_mgmt_register_bit_behaviour;
    import mgmt_pkg::*;
    logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, func_start, func_done;
    logic isolate, soft_reset_active, event_high, event_low_n;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [PEAK_W-1:0] fsm_state, pk;
    logic [MODE_W-1:0] cfg_mode;
    logic [TEST_W-1:0] test_mode;
    logic [GUARD_W-1:0] guarded_cfg, g;
    logic [STRAP_W-1:0] straps;
    logic [3:0] lat;
    logic [15:0] m_ctrl;
    int fails, num_checks, cyc, starts, n;

    mgmt_bits i_dut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .addr_strap_pin_0(straps[0]),
        .addr_strap_pin_1(straps[1]), .addr_strap_pin_2(straps[2]), .addr_strap_pin_3(straps[3]),
        .addr_strap_pin_4(straps[4]), .event_high(event_high), .event_low_n(event_low_n),
        .fsm_state(fsm_state), .func_done(func_done), .func_start(func_start), .isolate(isolate),
        .cfg_mode(cfg_mode), .test_mode(test_mode), .guarded_cfg(guarded_cfg),
        .soft_reset_active(soft_reset_active));
    core_model i_core (.clock(clock), .rst_n(rst_n), .func_start(func_start), .lat(lat),
        .func_done(func_done));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // cycle watchdog and start pulse count, both on nba so readers never race
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (func_start === 1'b1)
            starts <= starts + 1;
        if (cyc == 5000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        num_checks++;
        if (v !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
        end
    endtask

    // handshakes judged at the falling edge, released just after the rising one
    task automatic wr(input logic [7:0] a, input logic [15:0] dv, input logic [1:0] er);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {16'h0000, dv};
        wstrb <= {2'($urandom), 2'b11};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(da && dw)) begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clock);
            if (ta) begin
                awvalid <= 1'b0;
                da = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                dw = 1'b1;
            end
        end
        @(negedge clock);
        while (bvalid !== 1'b1) @(negedge clock);
        chk("bresp", er, bresp);
        @(posedge clock);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clock);
        while (arready !== 1'b1) @(negedge clock);
        @(posedge clock);
        arvalid <= 1'b0;
        @(negedge clock);
        while (rvalid !== 1'b1) @(negedge clock);
        dv = rdata;
        rv = rresp;
        @(posedge clock);
        rready <= 1'b0;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", er, r);
    endtask

    // the whole default state, seen from the bus and from the mode, test and isolate outputs
    task automatic defaults();
        m_ctrl = {8'h00, MODE_RST, 1'b0, straps == STRAP_ZERO, 2'b00};
        rc("ctrl", OFS_CTRL, {16'h0000, m_ctrl}, RESP_OKAY);
        rc("status", OFS_STATUS, {30'h0, STICKY_LO_RST, STICKY_HI_RST}, RESP_OKAY);
        rc("peak", OFS_PEAK, {29'h0, PEAK_RST}, RESP_OKAY);
        rc("guard", OFS_GUARD, {24'h0, GUARD_RST}, RESP_OKAY);
        rc("strap", OFS_STRAP, {27'h0, straps}, RESP_OKAY);
        chk("test_mode", TEST_RST, test_mode);
        chk("isolate", straps == STRAP_ZERO, isolate);
        chk("cfg_mode", MODE_RST, cfg_mode);
    endtask

    initial begin
        void'($urandom(32'ha10f));
        {rst_n, awvalid, wvalid, bready, arvalid, rready, event_high} = 7'h00;
        {awaddr, araddr, wdata, wstrb, fsm_state} = '0;
        event_low_n = 1'b1;
        straps = 5'($urandom);
        lat = 4'd10;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        defaults();
        // one pulse on both monitored events, then two reads each
        event_high <= 1'b1;
        event_low_n <= 1'b0;
        @(posedge clock);
        event_high <= 1'b0;
        event_low_n <= 1'b1;
        rc("sticky first", OFS_STATUS, 32'h1, RESP_OKAY);
        rc("sticky second", OFS_STATUS, 32'h2, RESP_OKAY);
        // a peak followed by a lower state
        pk = 3'($urandom_range(7, 1));
        fsm_state <= pk;
        @(posedge clock);
        fsm_state <= pk - 3'd1;
        rc("peak first", OFS_PEAK, {29'h0, pk}, RESP_OKAY);
        rc("peak second", OFS_PEAK, {29'h0, pk - 3'd1}, RESP_OKAY);
        // trigger with a slow core, then with a prompt one
        wr(OFS_CTRL, m_ctrl | 16'h0002, RESP_OKAY);
        repeat (2) @(posedge clock);
        chk("starts", 1, starts);
        rc("busy", OFS_STATUS, 32'h6, RESP_OKAY);
        repeat (16) @(posedge clock);
        rc("idle", OFS_STATUS, 32'h2, RESP_OKAY);
        rc("trig clear", OFS_CTRL, {16'h0000, m_ctrl}, RESP_OKAY);
        lat <= 4'd0;
        wr(OFS_CTRL, m_ctrl | 16'h0002, RESP_OKAY);
        repeat (3) @(posedge clock);
        rc("prompt", OFS_STATUS, 32'h2, RESP_OKAY);
        chk("starts", 2, starts);
        // read-only and unmapped places
        wr(OFS_STRAP, 16'hffff, RESP_OKAY);
        rc("strap ro", OFS_STRAP, {27'h0, straps}, RESP_OKAY);
        wr(8'h20, 16'hffff, RESP_SLVERR);
        rc("unmapped", 8'h20, 32'h0, RESP_SLVERR);
        // guarded bits: refused, armed, taken once
        g = 8'($urandom) | 8'h01;
        wr(OFS_GUARD, {8'h00, g}, RESP_OKAY);
        rc("guard locked", OFS_GUARD, 32'h0, RESP_OKAY);
        m_ctrl[7:4] = 4'($urandom);
        wr(OFS_CTRL, m_ctrl | 16'h8000, RESP_OKAY);
        wr(OFS_GUARD, {8'h00, g}, RESP_OKAY);
        wr(OFS_GUARD, {8'h00, ~g}, RESP_OKAY);
        rc("guard once", OFS_GUARD, {24'h0, g}, RESP_OKAY);
        rc("override clear", OFS_CTRL, {16'h0000, m_ctrl}, RESP_OKAY);
        chk("guarded_cfg", g, guarded_cfg);
        chk("cfg_mode", m_ctrl[7:4], cfg_mode);
        // soft reset must bring every default back
        fsm_state <= '0;
        wr(OFS_CTRL, m_ctrl | 16'h0001, RESP_OKAY);
        chk("soft_reset_active", 1, soft_reset_active);
        n = 0;
        d = 32'h1;
        while (d[0] !== 1'b0 && n < 20) begin
            rd(OFS_CTRL, d, r);
            n++;
        end
        chk("soft done", 0, d[0]);
        repeat (4) @(posedge clock);
        defaults();
        chk("soft_reset_active", 0, soft_reset_active);
        complete_run();
    end
endmodule
